/* common/aout_slot_consts.svh */
// constants of the analog output slot decoder
// Behaviour
// - The block base address comes from six switch positions, each carrying one binary weight.
// - The base address is the sum of the weights of all switch positions that are on.
// - Each channel owns a two-byte word, so eight channels fill sixteen consecutive bytes.
// - Only the base is set from outside; channel addresses are decoded inside from it.
// - Channel n, n from 0 to 7, sits at the base plus two times n modulo 256; with a base above 240 the upper channels wrap to address 0.
// - With enable checking on and the enable input off, no block access is acknowledged.
// - While disabled by the enable input, every output keeps its last written value.
// - Jumper fitted gates acknowledge with the enable input; jumper open always responds.
// - The output inhibit command is ignored; each channel holds until rewritten.
// - Decoding depends only on the switch setting, never on the slot position.
`ifndef AOUT_SLOT_CONSTS_SVH
`define AOUT_SLOT_CONSTS_SVH

`define CHAN_COUNT        8
`define CHAN_BITS         3
`define WORD_BITS         16
`define BLOCK_BYTES       8'h10
`define SWITCH_POS        6
`define SWITCH_LSB_WEIGHT 2
`define BP_ADDR_BITS      8
`define AXI_ADDR_BITS     12
`define IDX_BITS          10
`define BP_IDX_LIMIT      10'h100
`define STATUS_IDX        10'h100
`define ST_BASE_LSB       0
`define ST_ENABLE_BIT     8
`define ST_JUMPER_BIT     9
`define ST_GATED_BIT      10
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3
`define CHAN_RESET        16'h0000

`endif

/* common/aout_slot_pkg.sv */
// types of the analog output slot decoder
package aout_slot_pkg;
	typedef logic [15:0] chanWord_t;

	typedef struct packed {
		logic       hit;
		logic [2:0] chan;
		logic       oddByte;
		logic       status;
	} decode_t;

	typedef struct packed {
		logic       gated;
		logic       jumperOpen;
		logic       enable;
		logic [7:0] base;
	} status_t;

	typedef enum {WR_COLLECT, WR_RESP} wrState_t;
	typedef enum {RD_COLLECT, RD_RESP} rdState_t;
endpackage

/* verilog/sync_2ff.sv */
// two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module sync_2ff #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,  // system clock
	input  wire logic             srst, // synchronous reset
	input  wire logic [WIDTH-1:0] d,    // asynchronous level
	output logic      [WIDTH-1:0] q     // synchronised level
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			stage1_reg <= '0;
			q          <= '0;
		end else begin
			stage1_reg <= d;
			q          <= stage1_reg;
		end
	end
endmodule

/* verilog/analog_output_slot_decoder.sv */
// axi4-lite front end of the eight channel analog output block
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "aout_slot_consts.svh"
module analog_output_slot_decoder
	import aout_slot_pkg::*;
#(
	parameter int CHANNELS = `CHAN_COUNT
) (
	input  wire logic        clk,                  // 50 mhz clock
	input  wire logic        srst,                 // synchronous reset, high
	input  wire logic [5:0]  addressSwitchBit,     // rocker levels, 1 = on
	input  wire logic        enableIn,             // external enable, 1 = powered
	input  wire logic        jumperOpen,           // 1 = enable jumper removed
	input  wire logic        outputInhibitCommand, // backplane inhibit, unused
	input  wire logic [11:0] s_axi_awaddr,         // write address
	input  wire logic        s_axi_awvalid,        // write address valid
	output logic             s_axi_awready,        // write address ready
	input  wire logic [31:0] s_axi_wdata,          // write data
	input  wire logic [3:0]  s_axi_wstrb,          // write strobes
	input  wire logic        s_axi_wvalid,         // write data valid
	output logic             s_axi_wready,         // write data ready
	output logic [1:0]       s_axi_bresp,          // write response
	output logic             s_axi_bvalid,         // write response valid
	input  wire logic        s_axi_bready,         // write response ready
	input  wire logic [11:0] s_axi_araddr,         // read address
	input  wire logic        s_axi_arvalid,        // read address valid
	output logic             s_axi_arready,        // read address ready
	output logic [31:0]      s_axi_rdata,          // read data
	output logic [1:0]       s_axi_rresp,          // read response
	output logic             s_axi_rvalid,         // read data valid
	input  wire logic        s_axi_rready,         // read data ready
	output chanWord_t        analogOut [CHANNELS], // held channel words
	output logic             gateClosed            // block accesses currently refused; status still answered
);

	logic [7:0]     pinSync;
	logic [5:0]     switchSync;
	logic           enableSync;
	logic           jumperSync;
	logic [7:0]     baseAddr;
	status_t        status;
	chanWord_t      chan_reg [CHANNELS];
	wrState_t       wrState_reg;
	rdState_t       rdState_reg;
	logic           awHave_reg;
	logic           wHave_reg;
	logic           arHave_reg;
	logic [9:0]     awIdx_reg;
	logic [9:0]     arIdx_reg;
	logic [7:0]     wByte_reg;
	logic           wLane_reg;
	decode_t        wrDec;
	decode_t        rdDec;
	logic           wrBlocked;
	logic           rdBlocked;
	logic           wrFire;
	logic           rdFire;
	logic [1:0]     bresp_reg;
	logic [1:0]     rresp_reg;
	logic [31:0]    rdata_reg;
	logic [CHANNELS*16-1:0] chanFlat;

	// inhibit is deliberately left unread: a channel keeps its word through it
	logic inhibitIgnored;
	assign inhibitIgnored = outputInhibitCommand & 1'b0;

	sync_2ff #(
		.WIDTH(8)
	) pinSyncU (
		.clk (clk),
		.srst(srst),
		.d   ({jumperOpen, enableIn, addressSwitchBit}),
		.q   (pinSync)
	);

	assign switchSync = pinSync[5:0];
	assign enableSync = pinSync[6];
	assign jumperSync = pinSync[7];

	// sum of on-rocker weights, lowest rocker weighs 2**SWITCH_LSB_WEIGHT
	function automatic logic [7:0] switch_base(input logic [5:0] sw);
		logic [7:0] sum;
		sum = 8'h00;
		for (int i = 0; i < `SWITCH_POS; i++) begin
			if (sw[i]) begin
				sum = sum + 8'((1 << (i + `SWITCH_LSB_WEIGHT)));
			end
		end
		return sum;
	endfunction

	assign baseAddr = switch_base(switchSync);

	// slot position never enters here, only the switch base
	function automatic decode_t decode(input logic [9:0] idx, input logic [7:0] base);
		decode_t    d;
		logic [7:0] off;
		d       = '0;
		off     = idx[7:0] - base;
		d.hit   = (idx < `BP_IDX_LIMIT) && (off < `BLOCK_BYTES);
		d.chan  = off[3:1];
		d.oddByte = off[0];
		d.status  = (idx == `STATUS_IDX);
		return d;
	endfunction

	assign wrDec = decode(awIdx_reg, baseAddr);
	assign rdDec = decode(arIdx_reg, baseAddr);

	// jumper open forces the gate open whatever the enable pin says
	assign gateClosed = !jumperSync && !enableSync;

	// a refused block access just waits: no response, the master times out
	assign wrBlocked = wrDec.hit && gateClosed;
	assign rdBlocked = rdDec.hit && gateClosed;

	assign wrFire = (wrState_reg == WR_COLLECT) && awHave_reg && wHave_reg && !wrBlocked;
	assign rdFire = (rdState_reg == RD_COLLECT) && arHave_reg && !rdBlocked;

	assign s_axi_awready = (wrState_reg == WR_COLLECT) && !awHave_reg;
	assign s_axi_wready  = (wrState_reg == WR_COLLECT) && !wHave_reg;
	assign s_axi_arready = (rdState_reg == RD_COLLECT) && !arHave_reg;
	assign s_axi_bvalid  = (wrState_reg == WR_RESP);
	assign s_axi_rvalid  = (rdState_reg == RD_RESP);
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			awHave_reg <= 1'b0;
			awIdx_reg  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHave_reg <= 1'b1;
			awIdx_reg  <= s_axi_awaddr[11:2];
		end else if (wrFire) begin
			awHave_reg <= 1'b0;
		end
	end

	// only byte lane 0 carries data; an unstrobed lane leaves the half alone
	always_ff @(posedge clk) begin
		if (srst) begin
			wHave_reg <= 1'b0;
			wByte_reg <= '0;
			wLane_reg <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHave_reg <= 1'b1;
			wByte_reg <= s_axi_wdata[7:0];
			wLane_reg <= s_axi_wstrb[0];
		end else if (wrFire) begin
			wHave_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wrState_reg <= WR_COLLECT;
			bresp_reg   <= `RESP_OKAY;
		end else begin
			unique case (wrState_reg)
				WR_COLLECT: begin
					if (wrFire) begin
						wrState_reg <= WR_RESP;
						bresp_reg   <= (wrDec.hit || wrDec.status) ? `RESP_OKAY : `RESP_DECERR;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						wrState_reg <= WR_COLLECT;
					end
				end
			endcase
		end
	end

	// even byte is the high half, odd byte the low half
	generate
		for (genvar n = 0; n < CHANNELS; n++) begin : chanGen
			always_ff @(posedge clk) begin
				if (srst) begin
					chan_reg[n] <= `CHAN_RESET;
				end else if (wrFire && wrDec.hit && wLane_reg && wrDec.chan == n) begin
					if (wrDec.oddByte) begin
						chan_reg[n][7:0] <= wByte_reg;
					end else begin
						chan_reg[n][15:8] <= wByte_reg;
					end
				end
			end
			assign analogOut[n] = chan_reg[n];
			assign chanFlat[n*16 +: 16] = chan_reg[n];
		end
	endgenerate

	assign status.gated      = gateClosed;
	assign status.jumperOpen = jumperSync;
	assign status.enable     = enableSync;
	assign status.base       = baseAddr;

	always_ff @(posedge clk) begin
		if (srst) begin
			arHave_reg <= 1'b0;
			arIdx_reg  <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			arHave_reg <= 1'b1;
			arIdx_reg  <= s_axi_araddr[11:2];
		end else if (rdFire) begin
			arHave_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdState_reg <= RD_COLLECT;
			rresp_reg   <= `RESP_OKAY;
			rdata_reg   <= '0;
		end else begin
			unique case (rdState_reg)
				RD_COLLECT: begin
					if (rdFire) begin
						rdState_reg <= RD_RESP;
						rresp_reg   <= `RESP_OKAY;
						if (rdDec.hit) begin
							rdata_reg <= {24'h000000, rdDec.oddByte ?
								chan_reg[rdDec.chan][7:0] : chan_reg[rdDec.chan][15:8]};
						end else if (rdDec.status) begin
							rdata_reg <= {21'h000000, status};
						end else begin
							rdata_reg <= '0;
							rresp_reg <= `RESP_DECERR;
						end
					end
				end
				RD_RESP: begin
					if (s_axi_rready) begin
						rdState_reg <= RD_COLLECT;
					end
				end
			endcase
		end
	end

	// checks

	sequence s_wr_pending;
		wrState_reg == WR_COLLECT && awHave_reg && wHave_reg;
	endsequence

	sequence s_rd_pending;
		rdState_reg == RD_COLLECT && arHave_reg;
	endsequence

	sequence s_even_write;
		wrFire && wrDec.hit && wLane_reg && !wrDec.oddByte;
	endsequence

	sequence s_odd_write;
		wrFire && wrDec.hit && wLane_reg && wrDec.oddByte;
	endsequence

	a_gate_no_bresp: assert property (@(posedge clk) disable iff (srst)
		(s_wr_pending and wrDec.hit && gateClosed) |=> !s_axi_bvalid)
		else $error("write answered while gate closed");

	a_gate_no_rresp: assert property (@(posedge clk) disable iff (srst)
		(s_rd_pending and rdDec.hit && gateClosed) |=> !s_axi_rvalid)
		else $error("read answered while gate closed");

	a_hold_while_off: assert property (@(posedge clk) disable iff (srst)
		gateClosed |=> $stable(chanFlat))
		else $error("output changed while disabled");

	a_jumper_open_ans: assert property (@(posedge clk) disable iff (srst)
		(s_wr_pending and jumperSync) |=> s_axi_bvalid)
		else $error("jumper open but write not answered");

	// pins reach the gate two edges late; skip edges still fed by reset
	a_enable_gate: assert property (@(posedge clk) disable iff (srst)
		(!$past(srst) && !$past(srst, 2)) |->
			gateClosed == (!$past(jumperOpen, 2) && !$past(enableIn, 2)))
		else $error("gate disagrees with jumper and enable");

	a_base_sum: assert property (@(posedge clk) disable iff (srst)
		baseAddr == {switchSync, 2'b00})
		else $error("base is not the sum of on weights");

	a_even_high_half: assert property (@(posedge clk) disable iff (srst)
		s_even_write |=> analogOut[$past(wrDec.chan)][15:8] == $past(wByte_reg))
		else $error("even byte did not load high half");

	a_odd_low_half: assert property (@(posedge clk) disable iff (srst)
		s_odd_write |=> analogOut[$past(wrDec.chan)][7:0] == $past(wByte_reg))
		else $error("odd byte did not load low half");

	a_no_write_hold: assert property (@(posedge clk) disable iff (srst)
		!wrFire |=> $stable(chanFlat))
		else $error("channel changed without a write");

	a_outside_decerr: assert property (@(posedge clk) disable iff (srst)
		(wrFire && !wrDec.hit && !wrDec.status) |=> s_axi_bvalid && s_axi_bresp == `RESP_DECERR)
		else $error("write outside block not refused");

	a_resp_held: assert property (@(posedge clk) disable iff (srst)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped before ready");

endmodule

/* sim/cpu_bus_model.sv */
// controller-side bus master model for the slot decoder
`timescale 1ns/10ps
module cpu_bus_model (
	input  wire logic        clk,     // clock
	output logic [11:0]      awaddr,  // wr addr
	output logic             awvalid, // wr addr valid
	input  wire logic        awready, // wr addr ready
	output logic [31:0]      wdata,   // wr data
	output logic [3:0]       wstrb,   // wr strobes
	output logic             wvalid,  // wr data valid
	input  wire logic        wready,  // wr data ready
	input  wire logic [1:0]  bresp,   // wr resp
	input  wire logic        bvalid,  // wr resp valid
	output logic             bready,  // wr resp ready
	output logic [11:0]      araddr,  // rd addr
	output logic             arvalid, // rd addr valid
	input  wire logic        arready, // rd addr ready
	input  wire logic [31:0] rdata,   // rd data
	input  wire logic [1:0]  rresp,   // rd resp
	input  wire logic        rvalid,  // rd valid
	output logic             rready   // rd ready
);
	initial begin
		awaddr = 12'h000;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 12'h000;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	task automatic hang();
		tb_analog_output_slot_decoder.failures++;
		$display("[ERR] bus answer expected 1 seen 0");
		tb_analog_output_slot_decoder.print_verdict();
	endtask

	task automatic busWrite(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
		output logic [1:0] r);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, v};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(posedge clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a; // released lines must not keep a plausible value
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~{24'h0, v};
			end
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) hang();
	endtask

	task automatic busRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(posedge clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) hang();
	endtask
endmodule

/* sim/tb_analog_output_slot_decoder.sv */
// self-checking bench of the analog output slot decoder
`timescale 1ns/10ps
`include "aout_slot_consts.svh"
module tb_analog_output_slot_decoder
	import aout_slot_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [5:0]  sw = 6'h00;
	logic        enableIn = 1'b0;
	logic        jumperOpen = 1'b1;
	logic        inhibit = 1'b0;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, gateClosed;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp, rdResp;
	logic [7:0]  base;
	chanWord_t   analogOut [8];
	chanWord_t   expWord [8];
	int          failures = 0;
	int          tests_run = 0;

	always #10 clk = ~clk;

	analog_output_slot_decoder i_dut (
		.clk(clk), .srst(srst), .addressSwitchBit(sw), .enableIn(enableIn),
		.jumperOpen(jumperOpen), .outputInhibitCommand(inhibit),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.analogOut(analogOut), .gateClosed(gateClosed)
	);

	cpu_bus_model i_cpu (
		.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready)
	);

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic logic [7:0] expBase(input logic [5:0] s);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 6; i++)
			if (s[i]) b += 8'(4 << i);
		return b;
	endfunction

	function automatic logic [11:0] chAddr(input int n, input logic odd);
		logic [7:0] idx;
		idx = base + 8'(2 * n) + {7'h0, odd};
		return {2'b00, idx, 2'b00};
	endfunction

	task automatic wrChan(input int n, input logic odd, input logic [7:0] v);
		i_cpu.busWrite(chAddr(n, odd), v, 4'h1, resp);
		chk("bresp", `RESP_OKAY, resp);
		if (odd)
			expWord[n][7:0] = v;
		else
			expWord[n][15:8] = v;
		chk("chan", expWord[n], analogOut[n]);
		i_cpu.busRead(chAddr(n, odd), rd, resp);
		chk("rdata", {24'h0, v}, rd);
	endtask

	initial begin
		void'($urandom(80640));
		for (int i = 0; i < 8; i++)
			expWord[i] = `CHAN_RESET;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++)
			chk("reset", expWord[i], analogOut[i]);
		$display("test reset done");
		for (int k = 0; k < 4; k++) begin
			// base kept a multiple of sixteen; corners 240 and 0 first and last
			sw <= (k == 0) ? 6'h3c : (k == 3) ? 6'h00 : {4'($urandom), 2'b00};
			repeat (4) @(posedge clk);
			base = expBase(sw);
			i_cpu.busRead(12'h400, rd, resp);
			chk("base", {24'h0, base}, {24'h0, rd[7:0]});
			for (int n = 0; n < 8; n++) begin
				inhibit <= 1'($urandom);
				wrChan(n, 1'b0, 8'($urandom));
				wrChan(n, 1'b1, 8'($urandom));
			end
			i_cpu.busWrite({2'b00, base + 8'h10, 2'b00}, 8'h5a, 4'h1, resp);
			chk("decerr", `RESP_DECERR, resp);
			i_cpu.busRead({2'b00, base + 8'h10, 2'b00}, rd, resp);
			chk("rderr", `RESP_DECERR, resp);
			chk("rderr data", 0, rd);
			for (int n = 0; n < 8; n++)
				chk("hold", expWord[n], analogOut[n]);
			$display("test base %0d done", base);
		end
		// unstrobed lane must leave the half alone but still answer
		i_cpu.busWrite(chAddr(3, 1'b0), 8'hff, 4'h0, resp);
		chk("nostrb", `RESP_OKAY, resp);
		chk("nostrb chan", expWord[3], analogOut[3]);
		@(posedge clk);
		i_cpu.busWrite(12'h400, 8'h00, 4'h1, resp);
		chk("stwr", `RESP_OKAY, resp);
		$display("test corner done");
		jumperOpen <= 1'b0;
		repeat (4) @(posedge clk);
		chk("gate", 1, gateClosed);
		i_cpu.busRead(12'h400, rd, resp);
		chk("gated", 1, rd[10]);
		// one write and one read held back by the closed gate at once
		fork
			i_cpu.busWrite(chAddr(0, 1'b0), 8'ha5, 4'h1, resp);
			i_cpu.busRead(chAddr(1, 1'b1), rd, rdResp);
			begin
				repeat (30) @(posedge clk);
				chk("bvalid", 0, bvalid);
				chk("rvalid", 0, rvalid);
				chk("held", expWord[0], analogOut[0]);
				enableIn <= 1'b1;
			end
		join
		chk("bresp", `RESP_OKAY, resp);
		expWord[0][15:8] = 8'ha5;
		chk("chan", expWord[0], analogOut[0]);
		chk("rresp", `RESP_OKAY, rdResp);
		chk("rdata", {24'h0, expWord[1][7:0]}, rd);
		jumperOpen <= 1'b1;
		enableIn <= 1'b0;
		repeat (4) @(posedge clk);
		wrChan(7, 1'b1, 8'h3c);
		$display("test gate done");
		print_verdict();
	end
endmodule
